// ==== logic/fpmap_defines.vh ====
// Constants for the fault-line propagation and power-good mapping block.
// Assumes a 125 MHz system clock; included by the single design file.
`ifndef FPMAP_DEFINES_VH
`define FPMAP_DEFINES_VH
// Register selects on the page-addressed command port
`define FPMAP_SEL_PROP_A 2'h0
`define FPMAP_SEL_PROP_B 2'h1
`define FPMAP_SEL_GOOD_EN 2'h2
`define FPMAP_SEL_RESP 2'h3
// Field positions
`define FPMAP_PROP_BIT 0
`define FPMAP_GOOD_WDOG_BIT 8
// Reset values
`define FPMAP_PROP_RST 8'h00
`define FPMAP_GOOD_EN_RST 9'h000
`define FPMAP_RESP_RST 8'h00
// Timing: fault line must stay low this long before a response shutdown
`define FPMAP_LINE_HOLD_NS 10000
`define FPMAP_CLK_PERIOD_NS 8
`define FPMAP_LINE_HOLD_CYC ((`FPMAP_LINE_HOLD_NS + `FPMAP_CLK_PERIOD_NS - 1) / `FPMAP_CLK_PERIOD_NS)
`endif

// ==== logic/fpmap_top.v ====
// Fault-line propagation and power-good pin mapping for eight channels.
// Assumes per-channel fault and good status from same-clock logic and
// a page-addressed register port from the command interface.
// Summary of operation
// - Pages 0-3 drive only zone-0 lines
// - Pages 4-7 drive only zone-1 lines
// - Zone-0 line A pulled per enable
// - Zone-1 line A pulled per enable
// - Zone-0 line B pulled per enable
// - Zone-1 line B pulled per enable
// - Propagate bits 15:1 read zero
// - Response zero ignores low fault line
// - Good pin ANDs enabled channel statuses
// - Disabled channels excluded from good
// - Watchdog alive term when enabled
// - Watchdog ignored when disabled
// - Odd high-res channels never contribute
// - Good enable bits 15:9 read zero
// - Shutdown after 10us low; restart on release
`include "fpmap_defines.vh"
`timescale 1ns/1ps
`default_nettype none
module fpmap_top #(
    parameter NUM_CH = 8,
    parameter HOLD_CYC = `FPMAP_LINE_HOLD_CYC
) (
    // Clock and reset
    input wire SYS_CLK,
    input wire RESET,
    // Register port: page, select, write strobe and data
    input wire [2:0] REG_PAGE,
    input wire [1:0] REG_SEL,
    input wire REG_WR,
    input wire [15:0] REG_WDATA,
    output reg [15:0] REG_RDATA,
    // Channel status
    input wire [7:0] CH_FAULTED_OFF,
    input wire [7:0] CH_GOOD,
    input wire [7:0] CH_HIGH_RES,
    input wire WDOG_EXPIRED,
    // Shared fault lines: input, output, output enable (low = drive)
    input wire ZONE0_FAULT_LINE_A_IN,
    input wire ZONE0_FAULT_LINE_B_IN,
    input wire ZONE1_FAULT_LINE_A_IN,
    input wire ZONE1_FAULT_LINE_B_IN,
    output wire [3:0] ZONE_FAULT_LINE_OUT,
    output reg [3:0] ZONE_FAULT_LINE_OE_N,
    // Channel shutdown request and power-good pin
    output reg [7:0] CH_LINE_SHUTDOWN,
    output reg POWER_GOOD
);
    integer i;
    genvar g;
    // Line count is fixed by the pin-out: two zones of two lines
    localparam NUM_LINES = 4;
    // Low-time counter width; HOLD_CYC must stay below 2**HOLD_W
    localparam HOLD_W = 16;
    localparam [HOLD_W-1:0] HOLD_LIMIT = HOLD_CYC[HOLD_W-1:0];
    // Configuration registers
    reg [7:0] prop_a_reg;
    reg [7:0] prop_b_reg;
    reg [8:0] good_en_reg;
    reg [7:0] resp_a_reg;
    reg [7:0] resp_b_reg;
    // Write decode
    wire wr_prop_a;
    wire wr_prop_b;
    wire wr_good_en;
    wire wr_resp;
    // Line levels and drive requests
    wire [3:0] line_raw;
    wire [NUM_LINES-1:0] line_low;
    wire [NUM_LINES-1:0] drive_req;
    // Power-good votes and next values
    wire [NUM_CH-1:0] chan_ok;
    reg good_next;
    reg [15:0] rdata_next;
    reg [7:0] shut_next;

    assign line_raw = {ZONE1_FAULT_LINE_B_IN, ZONE1_FAULT_LINE_A_IN,
                       ZONE0_FAULT_LINE_B_IN, ZONE0_FAULT_LINE_A_IN};
    // Open-drain: the data level is always low, only the enable moves
    assign ZONE_FAULT_LINE_OUT = 4'h0;

    // Line index for channel c on line b (0 = A, 1 = B)
    function [1:0] line_of;
        input [2:0] ch;
        input bsel;
        begin
            line_of = {ch[2], bsel};
        end
    endfunction

    // Register select decode, shared by the write strobes
    function sel_hit;
        input [1:0] sel;
        input [1:0] code;
        begin
            sel_hit = (sel == code);
        end
    endfunction

    assign wr_prop_a = REG_WR && sel_hit(REG_SEL, `FPMAP_SEL_PROP_A);
    assign wr_prop_b = REG_WR && sel_hit(REG_SEL, `FPMAP_SEL_PROP_B);
    assign wr_good_en = REG_WR && sel_hit(REG_SEL, `FPMAP_SEL_GOOD_EN);
    assign wr_resp = REG_WR && sel_hit(REG_SEL, `FPMAP_SEL_RESP);

    // Propagate enables keep only bit 0 of the written word
    always @(posedge SYS_CLK) begin
        if (RESET) begin
            prop_a_reg <= `FPMAP_PROP_RST;
        end else if (wr_prop_a) begin
            prop_a_reg[REG_PAGE] <= REG_WDATA[`FPMAP_PROP_BIT];
        end
    end

    always @(posedge SYS_CLK) begin
        if (RESET) begin
            prop_b_reg <= `FPMAP_PROP_RST;
        end else if (wr_prop_b) begin
            prop_b_reg[REG_PAGE] <= REG_WDATA[`FPMAP_PROP_BIT];
        end
    end

    // Bits 15:9 are not stored at all, so they cannot read back
    always @(posedge SYS_CLK) begin
        if (RESET) begin
            good_en_reg <= `FPMAP_GOOD_EN_RST;
        end else if (wr_good_en) begin
            good_en_reg <= REG_WDATA[8:0];
        end
    end

    // Bit 0 for line A response, bit 1 for line B
    always @(posedge SYS_CLK) begin
        if (RESET) begin
            resp_a_reg <= `FPMAP_RESP_RST;
            resp_b_reg <= `FPMAP_RESP_RST;
        end else if (wr_resp) begin
            resp_a_reg[REG_PAGE] <= REG_WDATA[0];
            resp_b_reg[REG_PAGE] <= REG_WDATA[1];
        end
    end

    // Read mux, registered
    always @* begin
        rdata_next = 16'h0000;
        case (REG_SEL)
            `FPMAP_SEL_PROP_A: rdata_next = {15'h0000, prop_a_reg[REG_PAGE]};
            `FPMAP_SEL_PROP_B: rdata_next = {15'h0000, prop_b_reg[REG_PAGE]};
            `FPMAP_SEL_GOOD_EN: rdata_next = {7'h00, good_en_reg};
            `FPMAP_SEL_RESP: rdata_next = {14'h0000, resp_b_reg[REG_PAGE],
                                           resp_a_reg[REG_PAGE]};
            default: rdata_next = 16'h0000;
        endcase
    end

    // Drive requests: each line looks only at the channels of its own zone
    generate
        for (g = 0; g < NUM_LINES; g = g + 1) begin : g_drive
            localparam BASE = (g / 2) * 4;
            wire [3:0] enables;
            if (g % 2 == 0) begin : g_line_a
                assign enables = prop_a_reg[BASE +: 4];
            end else begin : g_line_b
                assign enables = prop_b_reg[BASE +: 4];
            end
            assign drive_req[g] = |(CH_FAULTED_OFF[BASE +: 4] & enables);
        end
    endgenerate

    // One channel's vote; a disabled or ineligible channel always votes
    // good so that it can never hold the pin low.
    function chan_vote;
        input en;
        input odd;
        input high_res;
        input good;
        begin
            if (!en) begin
                chan_vote = 1'b1;
            end else if (odd && high_res) begin
                chan_vote = 1'b1;
            end else begin
                chan_vote = good;
            end
        end
    endfunction

    generate
        for (g = 0; g < NUM_CH; g = g + 1) begin : g_vote
            // Odd channels in high-res mode measure current, not a rail
            assign chan_ok[g] = chan_vote(good_en_reg[g], (g % 2) == 1, CH_HIGH_RES[g],
                                          CH_GOOD[g]);
        end
    endgenerate

    // Power good: AND over the votes, plus the watchdog when enabled
    always @* begin
        good_next = &chan_ok;
        if (good_en_reg[`FPMAP_GOOD_WDOG_BIT] && WDOG_EXPIRED)
            good_next = 1'b0;
    end

    // Registered read data, one cycle after select and page
    always @(posedge SYS_CLK) begin
        if (RESET)
            REG_RDATA <= 16'h0000;
        else
            REG_RDATA <= rdata_next;
    end

    // Enables are registered so the shared pins never glitch low
    always @(posedge SYS_CLK) begin
        if (RESET)
            ZONE_FAULT_LINE_OE_N <= 4'hF;
        else
            ZONE_FAULT_LINE_OE_N <= ~drive_req;
    end

    always @(posedge SYS_CLK) begin
        if (RESET)
            POWER_GOOD <= 1'b0;
        else
            POWER_GOOD <= good_next;
    end

    // Three-stage capture of each shared line; the level changes only
    // once the last two stages agree, so a one-cycle glitch is ignored.
    generate
        for (g = 0; g < NUM_LINES; g = g + 1) begin : g_sync
            reg sync1_reg;
            reg sync2_reg;
            reg sync3_reg;
            reg low_reg;
            always @(posedge SYS_CLK) begin
                if (RESET) begin
                    // Released level, so no false low follows reset
                    sync1_reg <= 1'b1;
                    sync2_reg <= 1'b1;
                    sync3_reg <= 1'b1;
                    low_reg <= 1'b0;
                end else begin
                    sync1_reg <= line_raw[g];
                    sync2_reg <= sync1_reg;
                    sync3_reg <= sync2_reg;
                    if (!sync2_reg && !sync3_reg)
                        low_reg <= 1'b1;
                    else if (sync2_reg && sync3_reg)
                        low_reg <= 1'b0;
                end
            end
            assign line_low[g] = low_reg;
        end
    endgenerate

    // Per-line low-time counters; a short glitch never shuts a channel
    wire [3:0] line_held;
    generate
        for (g = 0; g < 4; g = g + 1) begin : g_hold
            reg [HOLD_W-1:0] cnt_reg;
            always @(posedge SYS_CLK) begin
                if (RESET)
                    cnt_reg <= 16'h0000;
                else if (!line_low[g])
                    cnt_reg <= 16'h0000;
                else if (cnt_reg < HOLD_LIMIT)
                    cnt_reg <= cnt_reg + 16'h0001;
            end
            // Saturates at the limit so a long fault never wraps around
            assign line_held[g] = (cnt_reg >= HOLD_LIMIT);
        end
    endgenerate

    // Shutdown lasts while the held line stays low; sequencing restarts
    // the channel with its own delay and rise settings after release.
    always @* begin
        shut_next = 8'h00;
        for (i = 0; i < NUM_CH; i = i + 1) begin
            shut_next[i] = (resp_a_reg[i] & line_held[line_of(i[2:0], 1'b0)]) |
                           (resp_b_reg[i] & line_held[line_of(i[2:0], 1'b1)]);
        end
    end

    always @(posedge SYS_CLK) begin
        if (RESET)
            CH_LINE_SHUTDOWN <= 8'h00;
        else
            CH_LINE_SHUTDOWN <= shut_next;
    end
endmodule // fpmap_top
`default_nettype wire

// ==== tb/fpmap_peer.sv ====
// Peer managers on the shared fault lines; assumes a pull-up on every line.
`timescale 1ns/1ps
`default_nettype none
module fpmap_peer (
    // Block enables and peer pulls
    input wire logic [3:0] oe_n,
    input wire logic [3:0] pull,
    // Wire levels
    output logic [3:0] line
);
    // Released lines go back to the pull-up level, never hold the last value
    assign line = oe_n & ~pull;
endmodule // fpmap_peer
`default_nettype wire

// ==== tb/fpmap_top_assertions.sv ====
// Port checks on fpmap_top; assumes HOLD_CYC is handed on by the bind.
`timescale 1ns/1ps
`default_nettype none
module fpmap_top_assertions #(parameter HOLD_CYC = 20) (
    // Clock and inputs
    input wire logic SYS_CLK,
    input wire logic RESET,
    input wire logic [7:0] CH_FAULTED_OFF,
    input wire logic [7:0] CH_GOOD,
    input wire logic WDOG_EXPIRED,
    input wire logic ZONE0_FAULT_LINE_A_IN,
    input wire logic ZONE0_FAULT_LINE_B_IN,
    // Outputs
    input wire logic [3:0] ZONE_FAULT_LINE_OUT,
    input wire logic [3:0] ZONE_FAULT_LINE_OE_N,
    input wire logic [7:0] CH_LINE_SHUTDOWN,
    input wire logic POWER_GOOD
);
    default clocking @(posedge SYS_CLK); endclocking
    default disable iff (RESET);
    sequence z0_high; ZONE0_FAULT_LINE_A_IN && ZONE0_FAULT_LINE_B_IN; endsequence
    sequence z0_idle; z0_high [*8]; endsequence
    chk_z0_owner: assert property (
        ZONE_FAULT_LINE_OE_N[1:0] != 2'h3 |-> $past(|CH_FAULTED_OFF[3:0])) else $error("z0 owner");
    chk_z1_owner: assert property (
        ZONE_FAULT_LINE_OE_N[3:2] != 2'h3 |-> $past(|CH_FAULTED_OFF[7:4])) else $error("z1 owner");
    chk_z0_free: assert property (
        CH_FAULTED_OFF[3:0] == 4'h0 |=> ZONE_FAULT_LINE_OE_N[1:0] == 2'h3) else $error("z0 free");
    chk_z1_free: assert property (
        CH_FAULTED_OFF[7:4] == 4'h0 |=> ZONE_FAULT_LINE_OE_N[3:2] == 2'h3) else $error("z1 free");
    chk_out_low: assert property (ZONE_FAULT_LINE_OUT == 4'h0) else $error("out");
    chk_good_all: assert property (
        &CH_GOOD && !WDOG_EXPIRED |=> POWER_GOOD) else $error("good");
    chk_hold_time: assert property (
        $rose(|CH_LINE_SHUTDOWN[3:0]) |-> !$past(ZONE0_FAULT_LINE_A_IN && ZONE0_FAULT_LINE_B_IN,
        HOLD_CYC)) else $error("hold");
    chk_line_free: assert property (
        z0_idle |=> CH_LINE_SHUTDOWN[3:0] == 4'h0) else $error("restart");
endmodule // fpmap_top_assertions
bind fpmap_top fpmap_top_assertions #(.HOLD_CYC(HOLD_CYC)) fpmap_top_assertions_inst (.SYS_CLK,
    .RESET, .CH_FAULTED_OFF, .CH_GOOD, .WDOG_EXPIRED, .ZONE0_FAULT_LINE_A_IN,
    .ZONE0_FAULT_LINE_B_IN, .ZONE_FAULT_LINE_OUT, .ZONE_FAULT_LINE_OE_N, .CH_LINE_SHUTDOWN,
    .POWER_GOOD);
`default_nettype wire

// ==== tb/tb.sv ====
// Bench for fpmap_top; the peer model resolves the shared fault lines.
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic SYS_CLK = 1'b0, RESET = 1'b1, REG_WR = 1'b0, WDOG_EXPIRED = 1'b0, POWER_GOOD;
    logic [2:0] REG_PAGE = 3'h0;
    logic [1:0] REG_SEL = 2'h0;
    logic [15:0] REG_WDATA = 16'h0000, REG_RDATA;
    logic [7:0] CH_FAULTED_OFF = 8'h00, CH_GOOD = 8'h00, CH_HIGH_RES = 8'h00, CH_LINE_SHUTDOWN;
    logic [3:0] pull = 4'h0, line, ZONE_FAULT_LINE_OUT, ZONE_FAULT_LINE_OE_N;
    int err_total = 0, compares = 0, cycles = 0;
    fpmap_top #(.HOLD_CYC(20)) fpmap_top_inst (.SYS_CLK, .RESET, .REG_PAGE, .REG_SEL, .REG_WR,
        .REG_WDATA, .REG_RDATA, .CH_FAULTED_OFF, .CH_GOOD, .CH_HIGH_RES, .WDOG_EXPIRED,
        .ZONE0_FAULT_LINE_A_IN(line[0]), .ZONE0_FAULT_LINE_B_IN(line[1]),
        .ZONE1_FAULT_LINE_A_IN(line[2]), .ZONE1_FAULT_LINE_B_IN(line[3]),
        .ZONE_FAULT_LINE_OUT, .ZONE_FAULT_LINE_OE_N, .CH_LINE_SHUTDOWN, .POWER_GOOD);
    fpmap_peer fpmap_peer_inst (.oe_n(ZONE_FAULT_LINE_OE_N), .pull, .line);
    initial begin
        forever #4 SYS_CLK = ~SYS_CLK;
    end
    always @(posedge SYS_CLK) begin
        cycles++;
        if (cycles == 2000) begin
            err_total++;
            end_sim();
        end
    end
    task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [2:0] p, input logic [1:0] s, input logic [15:0] d);
        @(negedge SYS_CLK);
        {REG_PAGE, REG_SEL, REG_WDATA, REG_WR} = {p, s, d, 1'b1};
        @(negedge SYS_CLK);
        REG_WR = 1'b0;
    endtask
    task automatic rd(input logic [2:0] p, input logic [1:0] s, input logic [15:0] e);
        @(negedge SYS_CLK);
        {REG_PAGE, REG_SEL} = {p, s};
        @(negedge SYS_CLK);
        cmp(REG_RDATA, e);
    endtask
    task automatic gchk(input logic [15:0] en, input logic [7:0] g, h, input logic w, e);
        wr(3'h0, 2'h2, en);
        {CH_GOOD, CH_HIGH_RES, WDOG_EXPIRED} = {g, h, w};
        repeat (2) @(negedge SYS_CLK);
        cmp({15'h0000, POWER_GOOD}, {15'h0000, e});
    endtask
    task automatic t_regs();
        rd(3'h0, 2'h2, 16'h0000);
        wr(3'h2, 2'h0, 16'hFFFF);
        rd(3'h2, 2'h0, 16'h0001);
        wr(3'h5, 2'h1, 16'hFFFE);
        rd(3'h5, 2'h1, 16'h0000);
        wr(3'h0, 2'h2, 16'hFFFF);
        rd(3'h0, 2'h2, 16'h01FF);
    endtask
    task automatic t_prop();
        // Even pages use line A, odd pages line B, so each line has two enabled channels
        for (int c = 0; c < 8; c++) begin
            wr(3'(c), 2'h0, 16'(~c & 1));
            wr(3'(c), 2'h1, 16'(c & 1));
        end
        for (int c = 0; c < 8; c++) begin
            CH_FAULTED_OFF = 8'h01 << c;
            repeat (2) @(negedge SYS_CLK);
            cmp({12'h000, ZONE_FAULT_LINE_OE_N}, {12'h000, 4'hF & ~(4'h1 << (c / 4 * 2 + c % 2))});
        end
        CH_FAULTED_OFF = 8'h00;
    endtask
    task automatic t_good();
        gchk(16'h0000, 8'h00, 8'h00, 1'b1, 1'b1);
        gchk(16'h0001, 8'hFE, 8'h00, 1'b0, 1'b0);
        gchk(16'h00FE, 8'hFE, 8'h00, 1'b0, 1'b1);
        gchk(16'h0082, 8'h7D, 8'h82, 1'b0, 1'b1);
        gchk(16'h0004, 8'h00, 8'h04, 1'b0, 1'b0);
        gchk(16'h0100, 8'hFF, 8'h00, 1'b1, 1'b0);
        gchk(16'h0100, 8'hFF, 8'h00, 1'b0, 1'b1);
    endtask
    task automatic t_resp();
        wr(3'h0, 2'h3, 16'h0001);
        pull = 4'h1;
        repeat (12) @(negedge SYS_CLK);
        cmp({8'h00, CH_LINE_SHUTDOWN}, 16'h0000);
        repeat (20) @(negedge SYS_CLK);
        cmp({8'h00, CH_LINE_SHUTDOWN}, 16'h0001);
        pull = 4'h0;
        repeat (10) @(negedge SYS_CLK);
        cmp({8'h00, CH_LINE_SHUTDOWN}, 16'h0000);
    endtask
    task automatic end_sim();
        $display("err_total %0d compares %0d", err_total, compares);
        if (err_total == 0 && compares > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (3) @(negedge SYS_CLK);
        RESET = 1'b0;
        t_regs();
        t_prop();
        t_good();
        t_resp();
        end_sim();
    end
endmodule // tb
`default_nettype wire
